// File: pcd_pkg.sv
// Shared constants and types for the program control decoder
package pcd_pkg;

  // Instruction classes recognised by the decoder
  typedef enum logic [3:0] {
    OP_ILLEGAL    = 4'h0,
    OP_LOOP       = 4'h1,
    OP_LOOP_EQ    = 4'h2,
    OP_LOOP_NE    = 4'h3,
    OP_LOOP_SHORT = 4'h4,
    OP_SWAP_PC    = 4'h5,
    OP_READ_PC    = 4'h6,
    OP_READ_ST    = 4'h7,
    OP_POP_ST     = 4'h8,
    OP_PUSH_ST    = 4'h9,
    OP_WRITE_ST   = 4'ha,
    OP_REL_SHORT  = 4'hb,
    OP_REL_LONG   = 4'hc,
    OP_ABS        = 4'hd
  } pcd_op_t;

  // Opcode prefixes and selectors
  localparam logic [7:0] PFX_LOOP = 8'h0d;
  localparam logic [7:0] PFX_CTX = 8'h01;
  localparam logic [3:0] NIB_LOOP_SHORT = 4'h3;
  localparam logic [3:0] NIB_JUMP = 4'hc;
  localparam logic [2:0] SEL_LOOP = 3'h4;
  localparam logic [2:0] SEL_LOOP_EQ = 3'h5;
  localparam logic [2:0] SEL_LOOP_NE = 3'h6;
  localparam logic [2:0] SEL_SWAP_PC = 3'h1;
  localparam logic [2:0] SEL_READ_PC = 3'h2;
  localparam logic [2:0] SEL_READ_ST = 3'h4;
  localparam logic [2:0] SEL_WRITE_ST = 3'h5;
  localparam logic [7:0] LOW_POP_ST = 8'hc0;
  localparam logic [7:0] LOW_PUSH_ST = 8'he0;
  localparam logic [7:0] LOW_REL_LONG = 8'h00;
  localparam logic [7:0] LOW_ABS = 8'h80;

  // Minimum cycle counts, taken and not taken
  localparam logic [3:0] CYC_LOOP_T = 4'h3;
  localparam logic [3:0] CYC_LOOP_N = 4'h2;
  localparam logic [3:0] CYC_SHORT_T = 4'h2;
  localparam logic [3:0] CYC_SHORT_N = 4'h3;
  localparam logic [3:0] CYC_SWAP_PC = 4'h2;
  localparam logic [3:0] CYC_READ = 4'h1;
  localparam logic [3:0] CYC_POP_ST = 4'h8;
  localparam logic [3:0] CYC_PUSH_ST = 4'h2;
  localparam logic [3:0] CYC_WRITE_ST = 4'h3;
  localparam logic [3:0] CYC_REL_S_T = 4'h2;
  localparam logic [3:0] CYC_REL_S_N = 4'h1;
  localparam logic [3:0] CYC_REL_L_T = 4'h3;
  localparam logic [3:0] CYC_REL_L_N = 4'h2;
  localparam logic [3:0] CYC_ABS_T = 4'h3;
  localparam logic [3:0] CYC_ABS_N = 4'h4;

  // Status word flag positions
  localparam int ST_N = 31;
  localparam int ST_C = 30;
  localparam int ST_Z = 29;
  localparam int ST_V = 28;

  // Program counter step per 16-bit word, and reset values
  localparam logic [31:0] PC_STEP = 32'h0000_0010;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;

endpackage : pcd_pkg

// File: pcd_decode.sv
// Opcode classifier: class, length in words and minimum cycle counts
`timescale 1ns/1ps
module pcd_decode (
  input wire logic [15:0] word_i,
  output pcd_pkg::pcd_op_t op_o,
  output logic [1:0] words_o,
  output logic [3:0] cyc_taken_o,
  output logic [3:0] cyc_not_o
);

  // Exact patterns first; the short jump takes what is left of its nibble
  always_comb begin
    op_o = pcd_pkg::OP_ILLEGAL;
    words_o = 2'd1;
    cyc_taken_o = pcd_pkg::CYC_READ;
    cyc_not_o = pcd_pkg::CYC_READ;
    if (word_i[15:8] == pcd_pkg::PFX_LOOP &&
        word_i[7:5] == pcd_pkg::SEL_LOOP) begin
      op_o = pcd_pkg::OP_LOOP;
      words_o = 2'd2;
      cyc_taken_o = pcd_pkg::CYC_LOOP_T;
      cyc_not_o = pcd_pkg::CYC_LOOP_N;
    end else if (word_i[15:8] == pcd_pkg::PFX_LOOP &&
                 (word_i[7:5] == pcd_pkg::SEL_LOOP_EQ ||
                  word_i[7:5] == pcd_pkg::SEL_LOOP_NE)) begin
      op_o = (word_i[7:5] == pcd_pkg::SEL_LOOP_EQ) ?
             pcd_pkg::OP_LOOP_EQ : pcd_pkg::OP_LOOP_NE;
      words_o = 2'd2;
      cyc_taken_o = pcd_pkg::CYC_LOOP_T;
      cyc_not_o = pcd_pkg::CYC_LOOP_N;
    end else if (word_i[15:12] == pcd_pkg::NIB_LOOP_SHORT && word_i[11]) begin
      op_o = pcd_pkg::OP_LOOP_SHORT;
      cyc_taken_o = pcd_pkg::CYC_SHORT_T;
      cyc_not_o = pcd_pkg::CYC_SHORT_N;
    end else if (word_i[15:8] == pcd_pkg::PFX_CTX) begin
      if (word_i[7:0] == pcd_pkg::LOW_POP_ST) begin
        op_o = pcd_pkg::OP_POP_ST;
        cyc_taken_o = pcd_pkg::CYC_POP_ST;
        cyc_not_o = pcd_pkg::CYC_POP_ST;
      end else if (word_i[7:0] == pcd_pkg::LOW_PUSH_ST) begin
        op_o = pcd_pkg::OP_PUSH_ST;
        cyc_taken_o = pcd_pkg::CYC_PUSH_ST;
        cyc_not_o = pcd_pkg::CYC_PUSH_ST;
      end else if (word_i[7:5] == pcd_pkg::SEL_SWAP_PC) begin
        op_o = pcd_pkg::OP_SWAP_PC;
        cyc_taken_o = pcd_pkg::CYC_SWAP_PC;
        cyc_not_o = pcd_pkg::CYC_SWAP_PC;
      end else if (word_i[7:5] == pcd_pkg::SEL_READ_PC) begin
        op_o = pcd_pkg::OP_READ_PC;
      end else if (word_i[7:5] == pcd_pkg::SEL_READ_ST) begin
        op_o = pcd_pkg::OP_READ_ST;
      end else if (word_i[7:5] == pcd_pkg::SEL_WRITE_ST) begin
        op_o = pcd_pkg::OP_WRITE_ST;
        cyc_taken_o = pcd_pkg::CYC_WRITE_ST;
        cyc_not_o = pcd_pkg::CYC_WRITE_ST;
      end
    end else if (word_i[15:12] == pcd_pkg::NIB_JUMP) begin
      if (word_i[7:0] == pcd_pkg::LOW_REL_LONG) begin
        op_o = pcd_pkg::OP_REL_LONG;
        words_o = 2'd2;
        cyc_taken_o = pcd_pkg::CYC_REL_L_T;
        cyc_not_o = pcd_pkg::CYC_REL_L_N;
      end else if (word_i[7:0] == pcd_pkg::LOW_ABS) begin
        op_o = pcd_pkg::OP_ABS;
        words_o = 2'd3;
        cyc_taken_o = pcd_pkg::CYC_ABS_T;
        cyc_not_o = pcd_pkg::CYC_ABS_N;
      end else begin
        op_o = pcd_pkg::OP_REL_SHORT;
        cyc_taken_o = pcd_pkg::CYC_REL_S_T;
        cyc_not_o = pcd_pkg::CYC_REL_S_N;
      end
    end
  end

endmodule : pcd_decode

// File: pcd_core.sv
// Program control decoder and sequencer with fetch, register and stack ports
// Function
// - loop decrement: two words, low 100R DDDD, 3/2
// - equal/not-equal loop variants: 101R, 110R, 3/2
// - short loop: one word, nibble 0011, 2/3
// - swap PC with register, 001R DDDD, 2
// - read PC into register, 010R DDDD, 1
// - read status into register, 100R DDDD, 1
// - pop status from stack, 1100 0000, 8
// - push status onto stack, 1110 0000, 2
// - write status from register, 101R DDDD, 3
// - short relative jump, 8-bit displacement, 2/1
// - long relative jump, zero low byte, 3/2
// - absolute jump, three words, 1000 0000, 3/4
`timescale 1ns/1ps
module pcd_core (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic fetch_valid_i,
  input wire logic [15:0] fetch_word_i,
  output logic fetch_ready_o,
  output logic [31:0] fetch_addr_o,
  output logic [4:0] rf_sel_o,
  input wire logic [31:0] rf_rdata_i,
  output logic rf_we_o,
  output logic [31:0] rf_wdata_o,
  input wire logic [31:0] st_i,
  output logic st_we_o,
  output logic [31:0] st_wdata_o,
  output logic stk_req_o,
  output logic stk_we_o,
  output logic [31:0] stk_wdata_o,
  input wire logic stk_ack_i,
  input wire logic [31:0] stk_rdata_i,
  output logic done_o,
  output logic taken_o,
  output logic illegal_o
);

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_EXT = 4'b0010,
    S_STK = 4'b0100,
    S_EXE = 4'b1000
  } pcd_state_t;

  pcd_state_t state_q;
  pcd_pkg::pcd_op_t op_q;
  pcd_pkg::pcd_op_t dec_op;
  logic [1:0] dec_words, left_q;
  logic [3:0] dec_cyc_t, dec_cyc_n, cyc_t_q, cyc_n_q, cnt_q, need;
  logic [15:0] ir_q;
  logic [31:0] ext_q, pc_q, stk_q, stk_wd_q, dec_val, target;
  logic ext_hi_q, accept, loop_go, taken, fin;

  // Condition code evaluation against the arithmetic flags
  function automatic logic cond_met(input logic [3:0] code,
                                    input logic [31:0] st);
    logic n, c, z, v;
    n = st[pcd_pkg::ST_N];
    c = st[pcd_pkg::ST_C];
    z = st[pcd_pkg::ST_Z];
    v = st[pcd_pkg::ST_V];
    case (code)
      4'h0: cond_met = 1'b1;
      4'h1: cond_met = c;
      4'h2: cond_met = c | z;
      4'h3: cond_met = ~c & ~z;
      4'h4: cond_met = n ^ v;
      4'h5: cond_met = ~(n ^ v);
      4'h6: cond_met = (n ^ v) | z;
      4'h7: cond_met = ~(n ^ v) & ~z;
      4'h8: cond_met = c;
      4'h9: cond_met = ~c;
      4'ha: cond_met = z;
      4'hb: cond_met = ~z;
      4'hc: cond_met = v;
      4'hd: cond_met = ~v;
      4'he: cond_met = n;
      default: cond_met = ~n;
    endcase
  endfunction : cond_met

  pcd_decode u_decode (
    .word_i(fetch_word_i),
    .op_o(dec_op),
    .words_o(dec_words),
    .cyc_taken_o(dec_cyc_t),
    .cyc_not_o(dec_cyc_n)
  );

  // Handshakes; the stack request holds until the memory acknowledges
  assign fetch_ready_o = (state_q == S_IDLE) || (state_q == S_EXT);
  assign accept = fetch_ready_o && fetch_valid_i;
  assign fetch_addr_o = pc_q;
  assign rf_sel_o = ir_q[4:0];
  assign stk_req_o = (state_q == S_STK);
  assign stk_we_o = (op_q == pcd_pkg::OP_PUSH_ST);
  assign stk_wdata_o = stk_wd_q;

  // Branch decision and target; displacements count 16-bit words
  always_comb begin
    dec_val = rf_rdata_i - 32'h0000_0001;
    loop_go = 1'b0;
    taken = 1'b0;
    target = pc_q;
    case (op_q)
      pcd_pkg::OP_LOOP, pcd_pkg::OP_LOOP_SHORT: loop_go = 1'b1;
      pcd_pkg::OP_LOOP_EQ: loop_go = st_i[pcd_pkg::ST_Z];
      pcd_pkg::OP_LOOP_NE: loop_go = ~st_i[pcd_pkg::ST_Z];
      default: loop_go = 1'b0;
    endcase
    case (op_q)
      pcd_pkg::OP_LOOP, pcd_pkg::OP_LOOP_EQ, pcd_pkg::OP_LOOP_NE: begin
        taken = loop_go && (dec_val != 32'h0000_0000);
        target = pc_q + ({{16{ext_q[15]}}, ext_q[15:0]} << 4);
      end
      pcd_pkg::OP_LOOP_SHORT: begin
        taken = (dec_val != 32'h0000_0000);
        // Direction bit set means a backward jump
        target = ir_q[10] ? pc_q - {23'h0, ir_q[9:5], 4'h0} :
                 pc_q + {23'h0, ir_q[9:5], 4'h0};
      end
      pcd_pkg::OP_REL_SHORT: begin
        taken = cond_met(ir_q[11:8], st_i);
        target = pc_q + ({{24{ir_q[7]}}, ir_q[7:0]} << 4);
      end
      pcd_pkg::OP_REL_LONG: begin
        taken = cond_met(ir_q[11:8], st_i);
        target = pc_q + ({{16{ext_q[15]}}, ext_q[15:0]} << 4);
      end
      pcd_pkg::OP_ABS: begin
        taken = cond_met(ir_q[11:8], st_i);
        target = ext_q;
      end
      pcd_pkg::OP_SWAP_PC: target = rf_rdata_i;
      default: taken = 1'b0;
    endcase
  end

  // Completion waits for both the work and the minimum count
  assign need = taken ? cyc_t_q : cyc_n_q;
  assign fin = (state_q == S_EXE) && (cnt_q >= need);

  // Sequencer state
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (accept) begin
            if (dec_words != 2'd1) begin
              state_q <= S_EXT;
            end else if (dec_op == pcd_pkg::OP_POP_ST ||
                         dec_op == pcd_pkg::OP_PUSH_ST) begin
              state_q <= S_STK;
            end else begin
              state_q <= S_EXE;
            end
          end
        end
        S_EXT: begin
          if (accept && left_q == 2'd1) begin
            state_q <= S_EXE;
          end
        end
        S_STK: begin
          if (stk_ack_i) begin
            state_q <= S_EXE;
          end
        end
        S_EXE: begin
          if (fin) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Instruction latch and extension words, low word first
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      op_q <= pcd_pkg::OP_ILLEGAL;
      ir_q <= 16'h0000;
      cyc_t_q <= 4'h1;
      cyc_n_q <= 4'h1;
      left_q <= 2'd0;
      ext_q <= 32'h0000_0000;
      ext_hi_q <= 1'b0;
      stk_wd_q <= 32'h0000_0000;
    end else if (state_q == S_IDLE && accept) begin
      op_q <= dec_op;
      ir_q <= fetch_word_i;
      cyc_t_q <= dec_cyc_t;
      cyc_n_q <= dec_cyc_n;
      left_q <= dec_words - 2'd1;
      ext_q <= 32'h0000_0000;
      ext_hi_q <= 1'b0;
      stk_wd_q <= st_i;
    end else if (state_q == S_EXT && accept) begin
      if (ext_hi_q) begin
        ext_q[31:16] <= fetch_word_i;
      end else begin
        ext_q[15:0] <= fetch_word_i;
      end
      ext_hi_q <= 1'b1;
      left_q <= left_q - 2'd1;
    end
  end

  // Cycle count since the first word was latched, saturating
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
    end else if (state_q == S_IDLE) begin
      cnt_q <= 4'h1;
    end else if (cnt_q != 4'hf) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Popped status word held until completion
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stk_q <= 32'h0000_0000;
    end else if (state_q == S_STK && stk_ack_i) begin
      stk_q <= stk_rdata_i;
    end
  end

  // Program counter: one step per fetched word, jump on completion
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pc_q <= pcd_pkg::PC_RESET;
    end else if (accept) begin
      pc_q <= pc_q + pcd_pkg::PC_STEP;
    end else if (fin && (taken || op_q == pcd_pkg::OP_SWAP_PC)) begin
      pc_q <= target;
    end
  end

  // Write-back outputs, registered one cycle after completion
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rf_we_o <= 1'b0;
      rf_wdata_o <= 32'h0000_0000;
      st_we_o <= 1'b0;
      st_wdata_o <= 32'h0000_0000;
      done_o <= 1'b0;
      taken_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      done_o <= fin;
      taken_o <= fin && taken;
      illegal_o <= fin && (op_q == pcd_pkg::OP_ILLEGAL);
      rf_we_o <= 1'b0;
      st_we_o <= 1'b0;
      if (fin) begin
        case (op_q)
          pcd_pkg::OP_LOOP, pcd_pkg::OP_LOOP_EQ, pcd_pkg::OP_LOOP_NE,
          pcd_pkg::OP_LOOP_SHORT: begin
            rf_we_o <= loop_go;
            rf_wdata_o <= dec_val;
          end
          pcd_pkg::OP_SWAP_PC, pcd_pkg::OP_READ_PC: begin
            rf_we_o <= 1'b1;
            rf_wdata_o <= pc_q;
          end
          pcd_pkg::OP_READ_ST: begin
            rf_we_o <= 1'b1;
            rf_wdata_o <= st_i;
          end
          pcd_pkg::OP_WRITE_ST: begin
            st_we_o <= 1'b1;
            st_wdata_o <= rf_rdata_i;
          end
          pcd_pkg::OP_POP_ST: begin
            st_we_o <= 1'b1;
            st_wdata_o <= stk_q;
          end
          default: rf_we_o <= 1'b0;
        endcase
      end
    end
  end

endmodule : pcd_core

// File: pcd_core_sva.sv
// Port-level assertions for the program control decoder
`timescale 1ns/1ps
module pcd_core_sva (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic fetch_valid_i,
  input wire logic [15:0] fetch_word_i,
  input wire logic fetch_ready_o,
  input wire logic rf_we_o,
  input wire logic st_we_o,
  input wire logic stk_req_o,
  input wire logic stk_we_o,
  input wire logic stk_ack_i,
  input wire logic done_o,
  input wire logic taken_o,
  input wire logic illegal_o
);
  logic busy_q;
  logic first;
  logic [15:0] w;
  // First word only; extension words must not start a new check
  assign first = fetch_valid_i && fetch_ready_o && (!busy_q || done_o);
  assign w = fetch_word_i;
  // Instruction in flight between first word and done
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
    end else if (first) begin
      busy_q <= 1'b1;
    end else if (done_o) begin
      busy_q <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  loop_min_a: assert property (first && w[15:8] == 8'h0d && w[7] &&
    w[6:5] != 2'b11 |=> !done_o [*2]) else $error("loop done too early");
  short_loop_a: assert property (first && w[15:11] == 5'h07 |->
    (##3 (done_o && taken_o)) or (##4 (done_o && !taken_o)))
    else $error("short loop timing wrong");
  swap_pc_a: assert property (first && w[15:5] == 11'h009 |=>
    !done_o [*2] ##1 (done_o && rf_we_o)) else $error("swap timing wrong");
  read_pc_a: assert property (first && w[15:5] == 11'h00a |->
    ##2 (done_o && rf_we_o)) else $error("pc read not in one cycle");
  read_st_a: assert property (first && w[15:5] == 11'h00c |->
    ##2 (done_o && rf_we_o)) else $error("status read not in one cycle");
  pop_min_a: assert property (first && w == 16'h01c0 |=>
    !done_o [*8]) else $error("pop finished too early");
  push_req_a: assert property (first && w == 16'h01e0 |=>
    stk_req_o && stk_we_o) else $error("push did not request stack");
  write_st_a: assert property (first && w[15:5] == 11'h00d |->
    ##4 (done_o && st_we_o)) else $error("status write timing wrong");
  short_jump_a: assert property (first && w[15:12] == 4'hc &&
    w[7:0] != 8'h00 && w[7:0] != 8'h80 |->
    (##2 (done_o && !taken_o)) or (##3 (done_o && taken_o)))
    else $error("short jump timing wrong");
  long_min_a: assert property (first && w[15:12] == 4'hc &&
    w[7:0] == 8'h00 |=> !done_o [*2]) else $error("long jump early");
  abs_min_a: assert property (first && w[15:12] == 4'hc &&
    w[7:0] == 8'h80 |=> !done_o [*3]) else $error("absolute jump early");
  stk_hold_a: assert property (stk_req_o && !stk_ack_i |=>
    stk_req_o && $stable(stk_we_o)) else $error("stack request dropped");
  cover property (done_o && taken_o);
  cover property (stk_req_o && !stk_ack_i);
  cover property (done_o && illegal_o);
endmodule : pcd_core_sva

bind pcd_core pcd_core_sva chk_u (.clk_sys_i, .rst_i, .fetch_valid_i,
  .fetch_word_i, .fetch_ready_o, .rf_we_o, .st_we_o, .stk_req_o, .stk_we_o,
  .stk_ack_i, .done_o, .taken_o, .illegal_o);

// File: program_control_decoder_tb.sv
// Self-checking testbench for the program control decoder
`timescale 1ns/1ps
module program_control_decoder_tb;
  localparam logic [31:0] ZF = 32'h2000_0000;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic fetch_valid_i = 1'b0;
  logic [15:0] fetch_word_i = 16'h0000;
  logic [31:0] rf_rdata_i = 32'h0;
  logic [31:0] st_i = 32'h0;
  logic stk_ack_i = 1'b1;
  logic [31:0] stk_rdata_i = 32'h9000_0000;
  logic fetch_ready_o, rf_we_o, st_we_o, stk_req_o, stk_we_o;
  logic done_o, taken_o, illegal_o;
  logic [31:0] fetch_addr_o, rf_wdata_o, st_wdata_o, stk_wdata_o;
  logic [4:0] rf_sel_o;
  logic d_we, d_swe, d_ill;
  logic [31:0] d_wd, d_swd, pc, p0;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  pcd_core dut_u (.clk_sys_i, .rst_i, .fetch_valid_i, .fetch_word_i,
    .fetch_ready_o, .fetch_addr_o, .rf_sel_o, .rf_rdata_i, .rf_we_o,
    .rf_wdata_o, .st_i, .st_we_o, .st_wdata_o, .stk_req_o, .stk_we_o,
    .stk_wdata_o, .stk_ack_i, .stk_rdata_i, .done_o, .taken_o, .illegal_o);

  always #2 clk_sys_i = ~clk_sys_i;

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run is under two hundred cycles; a hang counts as a mismatch
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Feeds one instruction; n numbers cycles with the accept cycle as 0
  task automatic op(input logic [63:0] w, input int nw,
    input logic [31:0] rd, input logic [31:0] st, input int stl,
    input int ed, input logic tk, input logic [31:0] npc);
    int k;
    int n;
    int s;
    logic acc;
    k = 0;
    n = -1;
    s = 0;
    @(posedge clk_sys_i);
    rf_rdata_i <= rd;
    st_i <= st;
    fetch_word_i <= w[15:0];
    fetch_valid_i <= 1'b1;
    repeat (60) begin
      @(negedge clk_sys_i);
      if (n >= 0 && done_o === 1'b1) break;
      acc = fetch_ready_o === 1'b1 && fetch_valid_i === 1'b1;
      @(posedge clk_sys_i);
      if (n >= 0) n++;
      if (acc) begin
        if (k == 0) n = 1; // Cycle after the accepting edge
        k++;
        fetch_word_i <= w[16*k +: 16];
        fetch_valid_i <= (k < nw) && (stl == 0);
        s = stl;
      end else if (s > 0) begin
        s--;
        fetch_valid_i <= (s == 0) && (k < nw);
      end
    end
    // A stall may only lengthen, never shorten, the count
    if (stl > 0) chk("slow_cycles", n > ed, 1'b1);
    else chk("cycles", n, ed);
    if (tk !== 1'bx) chk("taken", taken_o, tk);
    chk("pc", fetch_addr_o, npc);
    chk("sel", rf_sel_o, {27'h0, w[4:0]});
    d_we = rf_we_o;
    d_wd = rf_wdata_o;
    d_swe = st_we_o;
    d_swd = st_wdata_o;
    d_ill = illegal_o;
    pc = npc;
  endtask : op

  task automatic t_reset();
    chk("ready", fetch_ready_o, 1'b1);
    chk("addr", fetch_addr_o, 32'h0);
    chk("stk_req", stk_req_o, 1'b0);
    pc = 32'h0;
    $display("test reset done");
  endtask : t_reset

  task automatic t_loop();
    op(64'h0004_0d83, 2, 5, 0, 0, 4, 1, pc + 32'h60);
    chk("loop_wd", d_wd, 32'h4);
    op(64'h0004_0d83, 2, 1, 0, 0, 3, 0, pc + 32'h20);
    chk("loop_zero", d_wd, 32'h0);
    op(64'h0004_0da3, 2, 3, ZF, 0, 4, 1, pc + 32'h60);
    op(64'h0004_0dc3, 2, 3, ZF, 0, 3, 0, pc + 32'h20);
    chk("ne_we", d_we, 1'b0);
    op(64'h3843, 1, 2, 0, 0, 3, 1, pc + 32'h30);
    op(64'h3c23, 1, 5, 0, 0, 3, 1, pc);
    op(64'h3843, 1, 1, 0, 0, 4, 0, pc + 32'h10);
    $display("test loop done");
  endtask : t_loop

  task automatic t_ctx();
    p0 = pc;
    op(64'h0123, 1, 32'h200, 0, 0, 3, 1'bx, 32'h200);
    chk("swap_wd", d_wd, p0 + 32'h10);
    op(64'h0143, 1, 0, 0, 0, 2, 1'bx, pc + 32'h10);
    chk("rdpc_wd", d_wd, 32'h210);
    op(64'h0183, 1, 0, 32'ha000_0001, 0, 2, 1'bx, pc + 32'h10);
    chk("rdst_wd", d_wd, 32'ha000_0001);
    op(64'h01a3, 1, 32'h5000_0000, 0, 0, 4, 1'bx, pc + 32'h10);
    chk("wrst", {d_swe, d_swd[31:1]}, {1'b1, 31'h2800_0000});
    op(64'h01e0, 1, 0, 32'h1234_5678, 0, 3, 1'bx, pc + 32'h10);
    chk("push_wd", stk_wdata_o, 32'h1234_5678);
    op(64'h01c0, 1, 0, 0, 0, 9, 1'bx, pc + 32'h10);
    chk("pop_wd", d_swd, 32'h9000_0000);
    $display("test context done");
  endtask : t_ctx

  task automatic t_jump();
    logic t;
    for (int c = 0; c < 16; c++) begin
      t = (c == 0) || (c[0] && c != 1);
      op({52'hc, c[3:0], 8'h01}, 1, 0, 0, 0, t ? 3 : 2, t,
        pc + (t ? 32'h20 : 32'h10));
    end
    op(64'hc0fe, 1, 0, 0, 0, 3, 1, pc - 32'h10);
    op(64'h0003_c000, 2, 0, 0, 0, 4, 1, pc + 32'h50);
    op(64'h0003_ca00, 2, 0, 0, 0, 3, 0, pc + 32'h20);
    op(64'h0400_c080, 3, 0, 0, 0, 4, 1, 32'h400);
    op(64'h0400_ca80, 3, 0, 0, 0, 5, 0, pc + 32'h30);
    op(64'h0000, 1, 0, 0, 0, 2, 0, pc + 32'h10);
    chk("illegal", d_ill, 1'b1);
    $display("test jump done");
  endtask : t_jump

  task automatic t_stall();
    op(64'h0004_0d83, 2, 5, 0, 3, 4, 1, pc + 32'h60);
    @(posedge clk_sys_i);
    stk_ack_i <= 1'b0;
    fork
      op(64'h01c0, 1, 0, 0, 1, 9, 1'bx, pc + 32'h10);
      begin
        repeat (12) @(posedge clk_sys_i);
        stk_ack_i <= 1'b1;
      end
    join
    chk("pop_slow_wd", d_swd, 32'h9000_0000);
    $display("test stall done");
  endtask : t_stall

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    t_reset();
    t_loop();
    t_ctx();
    t_jump();
    t_stall();
    tally_and_finish();
  end
endmodule : program_control_decoder_tb
